// file: hdl/ucr_control_endpoint.sv
// ucr_control_endpoint: decodes and completes standard requests on the control pipe.
// assumes the core hands each setup packet over with a one-cycle strobe,
// pulses status_done when the status stage ends cleanly, and drains in_data.
`timescale 1ns/100ps

//
// Overview of operation
// - one-way endpoints: even receive, odd transmit
// - usb endpoint is controller endpoint halved, rounded down
// - endpoints 0,1 control, 3 bulk in, 4 bulk out, 7 interrupt in
// - one config, interface and alt setting; four endpoints; no streams
// - standard requests complete here; vendor requests are handed on to the core via vendor_req
// - bad or unsupported requests stall without halting the control pipe
// - descriptors live in a 128 by 32 ram loaded after reset
// - core passes a descriptor pointer used to locate the response
// - recipient 0 device, 1 interface, 2 endpoint; halt clear resets toggle
// - feature selectors: 0 halt or suspend, 1 wake, 48 u1, 49 u2, 50 ltm
// - index: endpoint 0,80h,81h,2,83h; device and interface zero
// - in superspeed, clearing halt resets that endpoint's sequence number
// - descriptor types 1,2,3,6,7 and 15 superspeed only; index byte zero
// - stall interface, endpoint, companion or wrong-speed descriptor requests
// - truncate to requested length; end short data with short or zero packet
// - superspeed device status gives ltm, u2, u1 and zero remote wake
// - superspeed interface status gives function wake and wake capable
// - self-powered status bit follows the power method select input
// - superspeed endpoint status takes endpoint from low index byte only
// - new address applies after status stage; other actions finish before it
// - configuration 1 enters configured state, 0 returns to address state
// - valid set configuration clears halts, resets toggles and sequences
// - set descriptor is always stalled
module ucr_control_endpoint #(
  parameter int unsigned RAM_WORDS   = ucr_pkg::DESC_RAM_WORDS,
  parameter bit          FUNC_WAKE_CAP = 1'b1
) (
  input  wire logic               core_clk,
  input  wire logic               arst_n,
  input  wire logic               clk_en,
  input  wire logic               setup_valid,
  input  wire ucr_pkg::ucr_setup_t setup,
  input  wire logic [6:0]         desc_ptr,
  input  wire logic               super_speed,
  input  wire logic               power_method_select,
  input  wire logic               status_done,
  input  wire logic               in_ready,
  input  wire logic               ram_wr_en,
  input  wire logic [6:0]         ram_wr_addr,
  input  wire logic [31:0]        ram_wr_data,
  output logic                    in_valid,
  output logic [7:0]              in_data,
  output logic                    in_last,
  output logic                    zlp_send,
  output logic                    stall,
  output logic                    vendor_req,
  output logic [6:0]              dev_addr,
  output logic                    configured,
  output logic [7:0]              ep_halt,
  output logic [7:0]              ep_seq_reset,
  output ucr_pkg::ucr_feat_t      features
);

  localparam int unsigned AW = $clog2(RAM_WORDS);

  // ram depth must be a power of two that a 7-bit pointer can reach
  if (RAM_WORDS > ucr_pkg::DESC_RAM_WORDS || RAM_WORDS < 2 || (1 << AW) != RAM_WORDS)
  begin : g_bad_depth
    $error("RAM_WORDS: power of two, 2 to 128");
  end

  typedef enum logic [2:0] {
    UCR_IDLE   = 3'b001,
    UCR_DATA   = 3'b010,
    UCR_STATUS = 3'b100
  } ucr_state_t;

  // endpoint address byte to controller endpoint index: {usb ep, direction}
  function automatic logic [2:0] ucr_ctrl_ep(input logic [7:0] ep_addr);
    ucr_ctrl_ep = {ep_addr[1:0], ep_addr[7]};
  endfunction : ucr_ctrl_ep

  // used endpoint with spare bits clear
  function automatic logic ucr_ep_ok(input logic [7:0] ep_addr);
    ucr_ep_ok = (ep_addr[6:2] == 5'h00) && ucr_pkg::USED_EP_MASK[ucr_ctrl_ep(ep_addr)];
  endfunction : ucr_ep_ok

  ucr_state_t           state_reg;
  logic [31:0]          ram_mem [RAM_WORDS];
  logic [15:0]          cnt_reg;
  logic [15:0]          len_reg;
  logic                 src_ram_reg;
  logic [6:0]           ptr_reg;
  logic [15:0]          resp_reg;
  logic                 zlp_need_reg;
  logic                 addr_pend_reg;
  logic [6:0]           addr_val_reg;
  logic [7:0]           halt_next;
  logic [7:0]           seq_rst_next;
  ucr_pkg::ucr_feat_t   feat_next;

  // setup field decode
  wire [1:0]  req_kind   = setup.request_type[6:5];
  wire [4:0]  rcp        = setup.request_type[4:0];
  wire        dir_in     = setup.request_type[7];
  wire        is_std     = (req_kind == ucr_pkg::TYPE_STD);
  wire [7:0]  idx_lo     = setup.index[7:0];
  wire [2:0]  ep_sel     = ucr_ctrl_ep(idx_lo);
  wire        idx_zero   = (setup.index == 16'h0000);
  wire        rcp_dev    = (rcp == ucr_pkg::RCP_DEVICE) && idx_zero;
  wire        rcp_if     = (rcp == ucr_pkg::RCP_IFACE) && (idx_lo == 8'h00);
  // superspeed ignores the high index byte for endpoint status only
  wire        ep_hi_ok   = (setup.index[15:8] == 8'h00);
  wire        rcp_ep     = (rcp == ucr_pkg::RCP_EP) && ucr_ep_ok(idx_lo) && ep_hi_ok;
  wire        rcp_ep_st  = (rcp == ucr_pkg::RCP_EP) && ucr_ep_ok(idx_lo)
                           && (ep_hi_ok || super_speed);
  wire [7:0]  dt         = setup.value[15:8];

  // descriptor header word: length byte or total length field
  wire [31:0] desc_hdr   = ram_mem[desc_ptr[AW-1:0]];
  wire        dt_total   = (dt == ucr_pkg::DT_CONFIG) || (dt == ucr_pkg::DT_OTHER_SPEED);
  wire [15:0] desc_len   = dt_total ? desc_hdr[31:16] : {8'h00, desc_hdr[7:0]};
  wire        dt_hs_only = (dt == ucr_pkg::DT_QUALIFIER) || (dt == ucr_pkg::DT_OTHER_SPEED);
  // interface, endpoint and companion types fall out as unsupported
  wire        dt_ok      = (dt == ucr_pkg::DT_DEVICE) || (dt == ucr_pkg::DT_CONFIG)
                           || (dt == ucr_pkg::DT_STRING)
                           || (dt_hs_only && !super_speed)
                           || ((dt == ucr_pkg::DT_BOS) && super_speed);

  // per request acceptance
  wire is_feat   = !dir_in && ((setup.request == ucr_pkg::REQ_CLR_FEATURE)
                   || (setup.request == ucr_pkg::REQ_SET_FEATURE));
  wire f_halt    = rcp_ep && (setup.value == ucr_pkg::FEAT_EP_HALT);
  wire f_wake    = rcp_dev && !super_speed && (setup.value == ucr_pkg::FEAT_REM_WAKE);
  wire f_u1      = rcp_dev && super_speed && (setup.value == ucr_pkg::FEAT_U1_EN);
  wire f_u2      = rcp_dev && super_speed && (setup.value == ucr_pkg::FEAT_U2_EN);
  wire f_ltm     = rcp_dev && super_speed && (setup.value == ucr_pkg::FEAT_LTM_EN);
  wire f_susp    = (rcp == ucr_pkg::RCP_IFACE) && (idx_lo == 8'h00) && super_speed
                   && (setup.value == ucr_pkg::FEAT_FUNC_SUSP);
  wire feat_ok   = is_feat && (f_halt || f_wake || f_u1 || f_u2 || f_ltm || f_susp);
  wire feat_set  = (setup.request == ucr_pkg::REQ_SET_FEATURE);

  wire st_ok     = dir_in && (setup.request == ucr_pkg::REQ_GET_STATUS)
                   && (setup.value == 16'h0000) && (rcp_dev || rcp_if || rcp_ep_st);
  wire gd_ok     = dir_in && (setup.request == ucr_pkg::REQ_GET_DESC)
                   && (rcp == ucr_pkg::RCP_DEVICE) && (setup.value[7:0] == 8'h00)
                   && dt_ok;
  wire gc_ok     = dir_in && (setup.request == ucr_pkg::REQ_GET_CONFIG) && rcp_dev;
  wire gi_ok     = dir_in && (setup.request == ucr_pkg::REQ_GET_IFACE) && rcp_if
                   && (setup.index[15:8] == 8'h00) && configured;
  wire sa_ok     = !dir_in && (setup.request == ucr_pkg::REQ_SET_ADDRESS) && rcp_dev
                   && (setup.value <= ucr_pkg::ADDR_MAX);
  wire sc_ok     = !dir_in && (setup.request == ucr_pkg::REQ_SET_CONFIG) && rcp_dev
                   && (setup.value <= ucr_pkg::CONFIG_MAX);
  // set descriptor has no accept term, so it always ends in a stall
  wire std_ok    = is_std && (feat_ok || st_ok || gd_ok || gc_ok || gi_ok || sa_ok || sc_ok);
  wire vend      = (req_kind == ucr_pkg::TYPE_VENDOR);

  // status words for get status
  wire [15:0] st_dev  = super_speed
                        ? 16'(({15'h0000, power_method_select} << ucr_pkg::ST_SELF_POWER)
                          | ({15'h0000, features.u1_enable} << ucr_pkg::ST_U1_EN)
                          | ({15'h0000, features.u2_enable} << ucr_pkg::ST_U2_EN)
                          | ({15'h0000, features.ltm_enable} << ucr_pkg::ST_LTM_EN))
                        : 16'(({15'h0000, power_method_select} << ucr_pkg::ST_SELF_POWER)
                          | ({15'h0000, features.remote_wake} << ucr_pkg::ST_REM_WAKE));
  wire [15:0] st_if   = super_speed
                        ? 16'(({15'h0000, FUNC_WAKE_CAP} << ucr_pkg::IST_WAKE_CAP)
                          | ({15'h0000, features.func_wake} << ucr_pkg::IST_WAKE_EN))
                        : 16'h0000;
  wire [15:0] st_ep   = {15'h0000, ep_halt[ep_sel]};
  wire [15:0] st_word = rcp_dev ? st_dev : (rcp_if ? st_if : st_ep);

  // data stage content, cut to the host's length
  wire [15:0] avail   = gd_ok ? desc_len : (st_ok ? 16'h0002 : 16'h0001);
  wire [15:0] send    = (setup.length < avail) ? setup.length : avail;
  wire [15:0] mps_msk = (super_speed ? ucr_pkg::EP0_MPS_SS : ucr_pkg::EP0_MPS_HS) - 16'h0001;
  wire        zlp_nd  = (send < setup.length) && ((send & mps_msk) == 16'h0000);
  wire [15:0] resp_w  = st_ok ? st_word : (gc_ok ? {15'h0000, configured} : 16'h0000);

  // byte source for the data stage
  wire [15:0] byte_addr = 16'({ptr_reg, 2'b00}) + cnt_reg;
  wire [31:0] ram_word  = ram_mem[byte_addr[AW+1:2]];
  wire [7:0]  ram_byte  = ram_word[8*byte_addr[1:0] +: 8];
  wire [7:0]  next_byte = src_ram_reg ? ram_byte : resp_reg[8*cnt_reg[0] +: 8];
  wire        take      = !in_valid || in_ready;
  wire        more      = (cnt_reg < len_reg);
  wire        accept    = setup_valid && std_ok;

  // updates from an accepted no-data request
  always_comb
  begin
    halt_next    = ep_halt;
    seq_rst_next = 8'h00;
    feat_next    = features;
    if (accept && feat_ok)
    begin
      if (f_halt)
      begin
        halt_next[ep_sel] = feat_set;
        // toggle at high/full speed, sequence number at superspeed
        seq_rst_next[ep_sel] = !feat_set;
      end
      if (f_wake) feat_next.remote_wake = feat_set;
      if (f_u1) feat_next.u1_enable = feat_set;
      if (f_u2) feat_next.u2_enable = feat_set;
      if (f_ltm) feat_next.ltm_enable = feat_set;
      if (f_susp) feat_next.func_wake = feat_set && setup.index[ucr_pkg::FSUSP_WAKE_BIT];
    end
    if (accept && sc_ok)
    begin
      halt_next    = 8'h00;
      seq_rst_next = ucr_pkg::USED_EP_MASK;
    end
  end

  // descriptor ram: flop storage written by the loader or driver
  always_ff @(posedge core_clk)
  begin
    if (clk_en && ram_wr_en)
      ram_mem[ram_wr_addr[AW-1:0]] <= ram_wr_data;
  end

  // endpoint and feature state, all settled before the status stage
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ep_halt      <= 8'h00;
      ep_seq_reset <= 8'h00;
      features     <= '0;
      configured   <= 1'b0;
    end
    else if (clk_en)
    begin
      ep_halt      <= halt_next;
      ep_seq_reset <= seq_rst_next;
      features     <= feat_next;
      if (accept && sc_ok)
        configured <= setup.value[0];
    end
  end

  // request sequencer; a fresh setup always restarts it
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg     <= UCR_IDLE;
      cnt_reg       <= 16'h0000;
      len_reg       <= 16'h0000;
      src_ram_reg   <= 1'b0;
      ptr_reg       <= 7'h00;
      resp_reg      <= 16'h0000;
      zlp_need_reg  <= 1'b0;
      addr_pend_reg <= 1'b0;
      addr_val_reg  <= ucr_pkg::RST_DEV_ADDR;
      dev_addr      <= ucr_pkg::RST_DEV_ADDR;
      in_valid      <= 1'b0;
      in_data       <= 8'h00;
      in_last       <= 1'b0;
      zlp_send      <= 1'b0;
      stall         <= 1'b0;
      vendor_req    <= 1'b0;
    end
    else if (clk_en)
    begin
      stall      <= 1'b0;
      zlp_send   <= 1'b0;
      vendor_req <= 1'b0;
      if (setup_valid)
      begin
        in_valid      <= 1'b0;
        in_last       <= 1'b0;
        cnt_reg       <= 16'h0000;
        len_reg       <= send;
        src_ram_reg   <= gd_ok;
        ptr_reg       <= desc_ptr;
        resp_reg      <= resp_w;
        zlp_need_reg  <= zlp_nd;
        addr_pend_reg <= accept && sa_ok;
        addr_val_reg  <= setup.value[6:0];
        vendor_req    <= vend;
        // no halt bit is touched here, only a stall pulse
        stall         <= !std_ok && !vend;
        if (!std_ok)
          state_reg <= UCR_IDLE;
        else if (dir_in && setup.length != 16'h0000)
          state_reg <= UCR_DATA;
        else
          state_reg <= UCR_STATUS;
      end
      else
      begin
        unique case (state_reg)
          UCR_IDLE:
            state_reg <= UCR_IDLE;
          UCR_DATA:
            if (take)
            begin
              in_valid <= more;
              if (more)
              begin
                in_data <= next_byte;
                in_last <= (cnt_reg == len_reg - 16'h0001);
                cnt_reg <= cnt_reg + 16'h0001;
              end
              else
              begin
                in_last   <= 1'b0;
                zlp_send  <= zlp_need_reg;
                state_reg <= UCR_STATUS;
              end
            end
          UCR_STATUS:
            if (status_done)
            begin
              state_reg <= UCR_IDLE;
              if (addr_pend_reg)
                dev_addr <= addr_val_reg;
              addr_pend_reg <= 1'b0;
            end
        endcase
      end
    end
  end

endmodule : ucr_control_endpoint

// file: hdl/ucr_pkg.sv
// ucr_pkg: constants and carrier types for the control endpoint request logic.
// assumes standard usb setup packet layout delivered whole by the device core.
package ucr_pkg;

  // controller endpoint map: bit set where a controller endpoint is in use
  localparam int unsigned NUM_CTRL_EP     = 8;
  localparam bit [7:0]    USED_EP_MASK    = 8'h9b;

  // descriptor ram geometry
  localparam int unsigned DESC_RAM_WORDS  = 128;
  localparam int unsigned DESC_RAM_WIDTH  = 32;

  // request type fields
  localparam bit [1:0]    TYPE_STD        = 2'h0;
  localparam bit [1:0]    TYPE_VENDOR     = 2'h2;
  localparam bit [4:0]    RCP_DEVICE      = 5'h00;
  localparam bit [4:0]    RCP_IFACE       = 5'h01;
  localparam bit [4:0]    RCP_EP          = 5'h02;

  // standard request codes
  localparam bit [7:0]    REQ_GET_STATUS  = 8'h00;
  localparam bit [7:0]    REQ_CLR_FEATURE = 8'h01;
  localparam bit [7:0]    REQ_SET_FEATURE = 8'h03;
  localparam bit [7:0]    REQ_SET_ADDRESS = 8'h05;
  localparam bit [7:0]    REQ_GET_DESC    = 8'h06;
  localparam bit [7:0]    REQ_SET_DESC    = 8'h07;
  localparam bit [7:0]    REQ_GET_CONFIG  = 8'h08;
  localparam bit [7:0]    REQ_SET_CONFIG  = 8'h09;
  localparam bit [7:0]    REQ_GET_IFACE   = 8'h0a;

  // feature selectors
  localparam bit [15:0]   FEAT_EP_HALT    = 16'h0000;
  localparam bit [15:0]   FEAT_FUNC_SUSP  = 16'h0000;
  localparam bit [15:0]   FEAT_REM_WAKE   = 16'h0001;
  localparam bit [15:0]   FEAT_U1_EN      = 16'h0030;
  localparam bit [15:0]   FEAT_U2_EN      = 16'h0031;
  localparam bit [15:0]   FEAT_LTM_EN     = 16'h0032;
  localparam int unsigned FSUSP_WAKE_BIT  = 9;

  // descriptor types
  localparam bit [7:0]    DT_DEVICE       = 8'h01;
  localparam bit [7:0]    DT_CONFIG       = 8'h02;
  localparam bit [7:0]    DT_STRING       = 8'h03;
  localparam bit [7:0]    DT_QUALIFIER    = 8'h06;
  localparam bit [7:0]    DT_OTHER_SPEED  = 8'h07;
  localparam bit [7:0]    DT_BOS          = 8'h0f;

  // status word bit positions
  localparam int unsigned ST_SELF_POWER   = 0;
  localparam int unsigned ST_REM_WAKE     = 1;
  localparam int unsigned ST_U1_EN        = 2;
  localparam int unsigned ST_U2_EN        = 3;
  localparam int unsigned ST_LTM_EN       = 4;
  localparam int unsigned IST_WAKE_CAP    = 0;
  localparam int unsigned IST_WAKE_EN     = 1;

  // limits and reset values
  localparam bit [15:0]   CONFIG_MAX      = 16'h0001;
  localparam bit [15:0]   ADDR_MAX        = 16'h007f;
  localparam bit [15:0]   EP0_MPS_HS      = 16'h0040;
  localparam bit [15:0]   EP0_MPS_SS      = 16'h0200;
  localparam bit [6:0]    RST_DEV_ADDR    = 7'h00;

  typedef struct packed {
    logic [7:0]  request_type;
    logic [7:0]  request;
    logic [15:0] value;
    logic [15:0] index;
    logic [15:0] length;
  } ucr_setup_t;

  typedef struct packed {
    logic remote_wake;
    logic u1_enable;
    logic u2_enable;
    logic ltm_enable;
    logic func_wake;
  } ucr_feat_t;

endpackage : ucr_pkg

// file: testbench/ucr_control_endpoint_bench.sv
// bench: directed scenarios for the control endpoint logic
// assumes the host model drives the setup side
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module ucr_control_endpoint_bench;
  logic core_clk, arst_n, super_speed, power_method_select, ram_wr_en;
  logic [6:0] ram_wr_addr, dev_addr, desc_ptr;
  logic [31:0] ram_wr_data;
  logic setup_valid, status_done, in_ready, in_valid, in_last, zlp_send, stall;
  logic vendor_req, configured;
  logic [7:0] in_data, ep_halt, ep_seq_reset;
  ucr_pkg::ucr_setup_t setup;
  ucr_pkg::ucr_feat_t features;
  int fails = 0;
  int n_compared = 0;
  ucr_control_endpoint DUT (
    .core_clk(core_clk), .arst_n(arst_n), .clk_en(1'b1), .setup_valid(setup_valid),
    .setup(setup), .desc_ptr(desc_ptr), .super_speed(super_speed),
    .power_method_select(power_method_select), .status_done(status_done),
    .in_ready(in_ready), .ram_wr_en(ram_wr_en), .ram_wr_addr(ram_wr_addr),
    .ram_wr_data(ram_wr_data), .in_valid(in_valid), .in_data(in_data), .in_last(in_last),
    .zlp_send(zlp_send), .stall(stall), .vendor_req(vendor_req), .dev_addr(dev_addr),
    .configured(configured), .ep_halt(ep_halt), .ep_seq_reset(ep_seq_reset),
    .features(features));
  ucr_host_model host (
    .core_clk(core_clk), .setup(setup), .setup_valid(setup_valid), .desc_ptr(desc_ptr),
    .status_done(status_done), .in_ready(in_ready), .in_valid(in_valid),
    .in_data(in_data), .in_last(in_last), .stall(stall), .vendor_req(vendor_req),
    .zlp_send(zlp_send), .ep_seq_reset(ep_seq_reset));
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic go(input logic [7:0] rt, rq, input logic [15:0] v, ix = 16'h0000, ln = 16'h0000,
                    input logic [6:0] p = 7'h00, input bit slow = 1'b0);
    host.xfer({rt, rq, v, ix, ln}, p, slow);
  endtask : go
  // one descriptor ram word per call, enable held from one falling edge to the next
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    @(negedge core_clk);
    {ram_wr_en, ram_wr_addr, ram_wr_data} = {1'b1, a, d};
    @(negedge core_clk);
    ram_wr_en = 1'b0;
  endtask : wr
  task automatic t_addr_cfg;
    go(8'h00, 8'h05, 16'h0005);
    `CHK(dev_addr, 7'h05)
    go(8'h00, 8'h09, 16'h0001);
    `CHK(configured, 1'b1)
    go(8'h02, 8'h03, 16'h0000, 16'h0081);
    go(8'h00, 8'h09, 16'h0001);
    `CHK(ep_halt, 8'h00)
    `CHK(host.seq_acc, 8'h9b)
    go(8'h00, 8'h09, 16'h0000);
    `CHK(configured, 1'b0)
    go(8'h00, 8'h09, 16'h0001);
  endtask : t_addr_cfg
  // halt set, refused request, clear; both speeds
  task automatic t_halt;
    logic [7:0] a[3] = '{8'h81, 8'h02, 8'h83};
    logic [7:0] m[3] = '{8'h08, 8'h10, 8'h80};
    for (int s = 0; s < 2; s++)
      for (int i = 0; i < 3; i++)
      begin
        super_speed = s[0];
        go(8'h02, 8'h03, 16'h0000, {8'h00, a[i]});
        `CHK(ep_halt, m[i])
        go(8'h00, 8'h07, 16'h0100);
        `CHK(host.saw_stall, 1'b1)
        `CHK(ep_halt, m[i])
        go(8'h02, 8'h01, 16'h0000, {8'h00, a[i]});
        `CHK(ep_halt, 8'h00)
        `CHK(host.seq_acc, m[i])
      end
  endtask : t_halt
  task automatic t_status;
    super_speed = 1'b0;
    go(8'h00, 8'h03, 16'h0001);
    `CHK(features.remote_wake, 1'b1)
    for (int p = 1; p >= 0; p--)
    begin
      power_method_select = p[0];
      go(8'h80, 8'h00, 16'h0000, 16'h0000, 16'h0002, 7'h00, 1'b1);
      `CHK(host.got.size(), 2)
      `CHK(host.got[0], {6'h00, 1'b1, p[0]})
      `CHK(host.got[1], 8'h00)
    end
    super_speed = 1'b1;
    go(8'h00, 8'h03, 16'h0030);
    go(8'h80, 8'h00, 16'h0000, 16'h0000, 16'h0002, 7'h00, 1'b1);
    `CHK(host.got[0], 8'h04)
    go(8'h00, 8'h01, 16'h0030);
    `CHK(features.u1_enable, 1'b0)
    go(8'h81, 8'h00, 16'h0000, 16'h0000, 16'h0002);
    `CHK(host.got[0], 8'h01)
  endtask : t_status
  task automatic t_desc;
    wr(7'h10, 32'h44332203);
    for (int i = 0; i < 16; i++)
      wr(7'h20 + i[6:0], (i == 0) ? 32'h00000040 : i);
    super_speed = 1'b0;
    go(8'h80, 8'h06, 16'h0100, 16'h0000, 16'h0002, 7'h10);
    `CHK({host.got.size(), host.got[0], host.got[1]}, {32'd2, 16'h0322})
    go(8'h80, 8'h06, 16'h0100, 16'h0000, 16'h0008, 7'h10);
    `CHK({host.got.size(), host.got[2], host.saw_zlp}, {32'd3, 8'h33, 1'b0})
    go(8'h80, 8'h06, 16'h0100, 16'h0000, 16'h0064, 7'h20);
    `CHK({host.got.size(), host.saw_zlp}, {32'd64, 1'b1})
    go(8'h80, 8'h06, 16'h0f00, 16'h0000, 16'h0002, 7'h10);
    `CHK(host.saw_stall, 1'b1)
    go(8'h80, 8'h06, 16'h0400, 16'h0000, 16'h0002, 7'h10);
    `CHK(host.saw_stall, 1'b1)
    go(8'h80, 8'h06, 16'h0101, 16'h0000, 16'h0002, 7'h10);
    `CHK(host.saw_stall, 1'b1)
    super_speed = 1'b1;
    go(8'h80, 8'h06, 16'h0f00, 16'h0000, 16'h0002, 7'h10);
    `CHK({host.saw_stall, host.got[0]}, {1'b0, 8'h03})
    go(8'h40, 8'ha0, 16'h0000, 16'h0000, 16'h0004);
    `CHK({host.saw_vend, host.saw_stall}, 2'b10)
  endtask : t_desc
  task automatic results;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results
  // watchdog: tests take well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge core_clk);
    fails++;
    results();
  end
  initial
  begin
    {arst_n, super_speed, power_method_select, ram_wr_en} = 4'h0;
    ram_wr_addr = 7'h00;
    ram_wr_data = 32'h00000000;
    repeat (20) @(negedge core_clk);
    arst_n = 1'b1;
    t_addr_cfg();
    t_halt();
    t_status();
    t_desc();
    results();
  end
endmodule : ucr_control_endpoint_bench

// file: testbench/ucr_control_endpoint_chk.sv
// checker: port-level assertions for the control endpoint logic
// assumes a single clock domain; attached by the bind after endmodule
`timescale 1ns/100ps
module ucr_control_endpoint_chk (
  input wire logic                core_clk,
  input wire logic                arst_n,
  input wire logic                clk_en,
  input wire logic                setup_valid,
  input wire ucr_pkg::ucr_setup_t setup,
  input wire logic                super_speed,
  input wire logic                status_done,
  input wire logic                stall,
  input wire logic                vendor_req,
  input wire logic [6:0]          dev_addr,
  input wire logic                configured,
  input wire logic [7:0]          ep_halt,
  input wire logic [7:0]          ep_seq_reset,
  input wire ucr_pkg::ucr_feat_t  features
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // setup taken at this edge, and its standard-type variant
  wire       take   = setup_valid && clk_en;
  wire       is_std = take && setup.request_type[6:5] == ucr_pkg::TYPE_STD;
  wire [7:0] rq     = setup.request;
  // only once addressed; default-state config is left open
  sequence s_cfg(v);
    is_std && rq == ucr_pkg::REQ_SET_CONFIG && setup.value[7:0] == v && dev_addr != 7'h00;
  endsequence
  sequence s_clr(rt, f, ix);
    take && setup.request_type == rt && rq == ucr_pkg::REQ_CLR_FEATURE
      && setup.value == f && setup.index == ix;
  endsequence
  property p_set_desc; is_std && rq == ucr_pkg::REQ_SET_DESC |=> stall; endproperty
  a_set_desc: assert property (p_set_desc)
    else $error("set descriptor not refused");
  property p_vendor;
    take && setup.request_type[6:5] == ucr_pkg::TYPE_VENDOR |=> vendor_req && !stall;
  endproperty
  a_vendor: assert property (p_vendor)
    else $error("vendor request not handed on");
  property p_keep_halt; stall |-> $stable(ep_halt); endproperty
  a_keep_halt: assert property (p_keep_halt)
    else $error("refusal changed endpoint halt");
  property p_addr; $changed(dev_addr) |-> $past(status_done); endproperty
  a_addr: assert property (p_addr)
    else $error("early address change");
  property p_cfg_on; s_cfg(8'h01) |=> configured && ep_halt == 8'h00; endproperty
  a_cfg_on: assert property (p_cfg_on)
    else $error("configuration 1 not applied");
  property p_cfg_seq; s_cfg(8'h01) |=> ep_seq_reset == ucr_pkg::USED_EP_MASK; endproperty
  a_cfg_seq: assert property (p_cfg_seq)
    else $error("no sequence reset");
  property p_cfg_off; s_cfg(8'h00) |=> !configured; endproperty
  a_cfg_off: assert property (p_cfg_off)
    else $error("still configured");
  property p_bos_hs;
    is_std && rq == ucr_pkg::REQ_GET_DESC && setup.value[15:8] == ucr_pkg::DT_BOS
      && !super_speed |=> stall;
  endproperty
  a_bos_hs: assert property (p_bos_hs)
    else $error("wrong-speed descriptor not refused");
  property p_clr_halt;
    s_clr(8'h02, ucr_pkg::FEAT_EP_HALT, 16'h0081) |=> !ep_halt[3] && ep_seq_reset[3];
  endproperty
  a_clr_halt: assert property (p_clr_halt)
    else $error("halt clear incomplete");
  property p_clr_u1;
    s_clr(8'h00, ucr_pkg::FEAT_U1_EN, 16'h0000) ##0 super_speed |=> !features.u1_enable;
  endproperty
  a_clr_u1: assert property (p_clr_u1)
    else $error("u1 enable not cleared");
  property p_unused; (ep_halt & ~ucr_pkg::USED_EP_MASK) == 8'h00; endproperty
  a_unused: assert property (p_unused)
    else $error("halt set on unused endpoint");
endmodule : ucr_control_endpoint_chk

bind ucr_control_endpoint ucr_control_endpoint_chk u_chk (
  .core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en), .setup_valid(setup_valid),
  .setup(setup), .super_speed(super_speed), .status_done(status_done), .stall(stall),
  .vendor_req(vendor_req), .dev_addr(dev_addr), .configured(configured),
  .ep_halt(ep_halt), .ep_seq_reset(ep_seq_reset), .features(features)
);

// file: testbench/ucr_host_model.sv
// host model: issues control transfers and collects the in data stage
// assumes block inputs change at the falling edge of core_clk
`timescale 1ns/100ps
module ucr_host_model (
  input  wire logic          core_clk,
  output ucr_pkg::ucr_setup_t setup,
  output logic               setup_valid,
  output logic [6:0]         desc_ptr,
  output logic               status_done,
  output logic               in_ready,
  input  wire logic          in_valid,
  input  wire logic [7:0]    in_data,
  input  wire logic          in_last,
  input  wire logic          stall,
  input  wire logic          vendor_req,
  input  wire logic          zlp_send,
  input  wire logic [7:0]    ep_seq_reset
);
  logic [7:0] got[$];
  logic       saw_stall, saw_vend, saw_zlp;
  logic [7:0] seq_acc;
  initial
  begin
    {setup, setup_valid, desc_ptr, status_done, in_ready} = '0;
  end
  // sticky records of one-cycle answers, cleared per transfer
  always @(posedge core_clk)
  begin
    saw_stall <= saw_stall | stall;
    saw_vend <= saw_vend | vendor_req;
    saw_zlp <= saw_zlp | zlp_send;
    seq_acc <= seq_acc | ep_seq_reset;
  end
  // setup, optional in stage, then status unless refused
  task automatic xfer(input ucr_pkg::ucr_setup_t s, input logic [6:0] p, input bit slow);
    bit done;
    int n;
    begin
      done = 1'b0;
      n = 0;
      got.delete();
      @(negedge core_clk);
      {saw_stall, saw_vend, saw_zlp, seq_acc} = '0;
      setup = s;
      desc_ptr = p;
      setup_valid = 1'b1;
      @(negedge core_clk);
      setup = ~s; // stale fields scrambled
      desc_ptr = ~p;
      setup_valid = 1'b0;
      while (s.request_type[7] && !done && !saw_stall && n < 400)
      begin
        in_ready = slow ? ~in_ready : 1'b1; // slow host stalls every other cycle
        if (in_valid && in_ready)
        begin
          got.push_back(in_data);
          done = in_last;
        end
        @(negedge core_clk);
        n++;
      end
      in_ready = 1'b0;
      repeat (3) @(negedge core_clk);
      if (!saw_stall)
      begin
        status_done = 1'b1;
        @(negedge core_clk);
        status_done = 1'b0;
      end
      repeat (2) @(negedge core_clk);
    end
  endtask : xfer
endmodule : ucr_host_model
